/* bench/lcdc_disp_model.sv */
// Purpose: Behavioural display module facing the controller pins
// Assumes: Controller pins are registered on clk
// Notes:   Released bus shows the inverse of its last level
`timescale 1ns/100ps
module lcdc_disp_model (
  input  wire logic       clk,        // Bench clock
  input  wire logic       rst,        // Controller reset
  input  wire logic [7:0] bus_out,    // Controller bus value
  input  wire logic       bus_oe,     // Controller drives bus
  input  wire logic       reg_select, // Register select
  input  wire logic       rw,         // Read select
  input  wire logic       strobe,     // Enable strobe
  output logic      [7:0] bus_in      // Resolved bus level
);
  logic [8:0]  log_q[$];       // Latched writes as {select, value}
  int          rd_at[$];       // Reads seen before each write
  time         tm_q[$];        // Time of each write
  int          n_rd   = 0;     // Busy reads seen
  int          n_bad  = 0;     // Pin discipline faults
  logic        busy_r = 1'b0;  // Busy after a data write
  logic        stb_r  = 1'b0;  // Strobe one clock ago
  logic [10:0] held_r = '0;    // Controls at strobe rise
  logic [7:0]  last_r = 8'h00; // Last bus level
  //****************************************************************************
  // Bus resolution
  //****************************************************************************
  always_comb begin
    if (bus_oe)
      bus_in = bus_out;
    else if (rw && strobe)
      bus_in = {busy_r, 7'h00}; // Busy flag only while enabled
    else
      bus_in = ~last_r;         // Never a stale value once released
  end
  //****************************************************************************
  // Latch on the strobe's falling edge
  //****************************************************************************
  always @(posedge clk) begin
    last_r <= bus_in;
    stb_r <= strobe;
    if (strobe && !stb_r)
      held_r <= {reg_select, rw, bus_oe, bus_out & {8{~rw}}};
    if (strobe && stb_r && {reg_select, rw, bus_oe, bus_out & {8{~rw}}} !== held_r)
      n_bad++;
    if (!strobe && stb_r && !rst) begin
      if (bus_oe === rw || rw !== held_r[9])
        n_bad++; // Drive only on writes
      if (rw === 1'b0) begin
        log_q.push_back({reg_select, bus_out});
        rd_at.push_back(n_rd);
        tm_q.push_back($time);
        busy_r <= reg_select; // Busy once after data
      end else begin
        n_rd++;
        busy_r <= 1'b0;
      end
    end
  end
endmodule : lcdc_disp_model

/* bench/lcdc_top_test.sv */
// Purpose: Self-checking bench of the character display controller
// Assumes: Shortened divider, step of 8 clocks, init wait of 3 steps
// Notes:   Message byte N is 8'h41 plus N
`timescale 1ns/100ps
module lcdc_top_test;
  logic       clk = 1'b0, rst = 1'b1, host_we_n = 1'b1, flash_valid = 1'b0;
  logic [7:0] host_char_in = 8'h00, flash_data = 8'h00, display_bus_in, display_bus_out;
  logic       display_bus_oe, display_reg_select, display_rw, display_strobe, host_ack, flash_read_n;
  logic [8:0] flash_addr;
  int         n_mismatch = 0, total_checks = 0, fl_idx = 0, fl_wait = 0;
  logic [7:0] init_tab [6] = '{8'h38, 8'h38, 8'h0F, 8'h01, 8'h06, 8'h80}; // Init commands
  initial forever #2 clk = ~clk;
  lcdc_top #(.OSC_DIV_P(6'h02), .STEP_DIV_P(8'h04), .WAIT_STEPS_P(10'h003)) lcdc_top_inst (.clk(clk),
    .rst(rst), .display_bus_in(display_bus_in), .display_bus_out(display_bus_out),
    .display_bus_oe(display_bus_oe), .display_reg_select(display_reg_select), .display_rw(display_rw),
    .display_strobe(display_strobe), .host_char_in(host_char_in), .host_we_n(host_we_n),
    .host_ack(host_ack), .flash_addr(flash_addr), .flash_read_n(flash_read_n),
    .flash_data(flash_data), .flash_valid(flash_valid));
  lcdc_disp_model m (.clk(clk), .rst(rst), .bus_out(display_bus_out), .bus_oe(display_bus_oe),
    .reg_select(display_reg_select), .rw(display_rw), .strobe(display_strobe), .bus_in(display_bus_in));
  //****************************************************************************
  // Message flash: slow answer, junk while not valid
  //****************************************************************************
  always @(posedge clk) begin
    if (flash_read_n === 1'b0 && !flash_valid) begin
      if (fl_wait == 2) begin
        check("flash_addr", 16'(fl_idx), 16'(flash_addr));
        flash_data <= 8'h41 + flash_addr[7:0];
        flash_valid <= 1'b1;
        fl_wait <= 0;
        fl_idx <= fl_idx + 1;
      end else begin
        fl_wait <= fl_wait + 1;
        flash_data <= ~flash_data; // Junk until valid
      end
    end else begin
      flash_valid <= 1'b0;
    end
  end
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : check
  task automatic timeout(input string what);
    n_mismatch++;
    $display("BAD %s exp done got hang", what);
    results();
  endtask : timeout
  // Boot: init commands with fixed waits, then the stored message
  task automatic t_boot(input int b);
    int i;
    int p;
    for (i = 0; i < 30000 && m.log_q.size() < b + 40; i++) @(posedge clk);
    if (i == 30000) timeout("boot");
    for (i = 0; i < 6; i++) check("init_cmd", {7'h00, 1'b0, init_tab[i]}, 16'(m.log_q[b+i]));
    check("init_polls", 16'h0000, 16'(m.rd_at[b+5] - m.rd_at[b]));
    check("init_gap", 16'h0001, 16'(m.tm_q[b+1] - m.tm_q[b] >= 7 * 32));
    for (i = 0; i < 32; i++) begin
      p = b + 6 + i + (i > 15);
      check("msg_char", {7'h00, 1'b1, 8'h41 + 8'(i)}, 16'(m.log_q[p]));
      check("msg_polls", 16'h0002, 16'(m.rd_at[p+1] - m.rd_at[p]));
    end
    check("row_two", 16'h00C0, 16'(m.log_q[b+22]));
    check("row_one", 16'h0080, 16'(m.log_q[b+39]));
  endtask : t_boot
  // Host character: one write, ack after polls, late data ignored
  task automatic t_host(input logic [7:0] c);
    int i;
    int n;
    n = m.log_q.size();
    host_char_in <= c;
    host_we_n <= 1'b0;
    for (i = 0; i < 4000 && host_ack !== 1'b1; i++) @(posedge clk);
    if (i == 4000) timeout("ack_high");
    check("host_write", {7'h00, 1'b1, c}, 16'(m.log_q[n]));
    check("host_polls", 16'h0002, 16'(m.n_rd - m.rd_at[n]));
    host_char_in <= ~c;
    host_we_n <= 1'b1;
    for (i = 0; i < 400 && host_ack !== 1'b0; i++) @(posedge clk);
    if (i == 400) timeout("ack_low");
    repeat (300) @(posedge clk);
    check("one_write", 16'(n + 1), 16'(m.log_q.size()));
  endtask : t_host
  // Reset mid-run: pins idle, whole boot reruns
  task automatic t_reset;
    rst <= 1'b1;
    host_we_n <= 1'b0;
    repeat (2) @(posedge clk);
    check("rst_pins", 16'h1000, {display_strobe, display_bus_oe, host_ack, flash_read_n, flash_addr, 3'h0});
    rst <= 1'b0;
    host_we_n <= 1'b1;
    fl_idx = 0;
    @(posedge clk);
    t_boot(m.log_q.size());
  endtask : t_reset
  task automatic results;
    if (n_mismatch == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_boot(0);
    t_host(8'h5A);
    t_host(8'h3C);
    t_reset();
    check("pin_faults", 16'h0000, 16'(m.n_bad));
    results();
  end
endmodule : lcdc_top_test

/* src/lcdc_pkg.sv */
//******************************************************************************
// Purpose: Shared constants, types and command table of the character display controller
// Assumes: 250 MHz system clock; display module with an on-board controller
// Notes:   Oscillator and divided clock are cycle enables, never real clocks
//******************************************************************************
package lcdc_pkg;

  //****************************************************************************
  // Timing
  //****************************************************************************
  localparam int unsigned CLK_HZ       = 250_000_000; // System clock rate
  localparam int unsigned OSC_HZ       = 5_500_000;   // Internal oscillator rate
  localparam int unsigned STEP_HZ      = 43_000;      // Divided sequencer rate
  localparam int unsigned INIT_WAIT_MS = 15;          // Wait after each init command
  // Oscillator enable period, rounded down (45 clocks)
  localparam logic [5:0]  OSC_DIV      = 6'(CLK_HZ / OSC_HZ);
  // Oscillator ticks per sequencer step (127)
  localparam logic [7:0]  STEP_DIV     = 8'(OSC_HZ / STEP_HZ);
  // Least wait in sequencer steps, rounded up (645)
  localparam logic [9:0]  WAIT_STEPS   = 10'((INIT_WAIT_MS * STEP_HZ + 999) / 1000);

  //****************************************************************************
  // Widths and sizes
  //****************************************************************************
  localparam int unsigned BUS_W    = 8;       // Display bus width
  localparam int unsigned ADDR_W   = 9;       // Message flash address width
  localparam logic [4:0]  MSG_LAST = 5'h1F;   // Last message character index
  localparam logic [4:0]  ROW1_POS = 5'h10;   // First position of second row
  localparam logic [2:0]  INIT_LAST = 3'h5;   // Last init command index
  localparam int unsigned BUSY_BIT = 7;       // Busy flag position on the bus
  localparam int unsigned IN_W     = 17;      // Synchronised input vector width
  localparam logic [16:0] IN_RST   = 17'h10000; // Write request idles high

  //****************************************************************************
  // Display commands
  //****************************************************************************
  localparam logic [7:0] CMD_FUNC  = 8'h38; // 8-bit bus, two lines
  localparam logic [7:0] CMD_ON    = 8'h0F; // Display on, blinking cursor
  localparam logic [7:0] CMD_CLEAR = 8'h01; // Clear and home
  localparam logic [7:0] CMD_ENTRY = 8'h06; // Increment cursor
  localparam logic [7:0] CMD_ROW0  = 8'h80; // Cursor to first row
  localparam logic [7:0] CMD_ROW1  = 8'hC0; // Cursor to second row

  // Bus cycle phases, one per sequencer step
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_HIGH  = 2'h1;
  localparam logic [1:0] PH_LOW   = 2'h2;
  localparam logic [1:0] PH_HOLD  = 2'h3;

  //****************************************************************************
  // Types
  //****************************************************************************
  typedef enum logic [2:0] {
    ST_POWER, ST_INIT_CMD, ST_INIT_WAIT, ST_MSG_READ,
    ST_WRITE, ST_BUSY_RD, ST_IDLE, ST_ACK
  } lcdc_state_type;

  // Display pin group, all driven from flip-flops
  typedef struct packed {
    logic             reg_select; // Low command, high data
    logic             read_sel;   // Low write, high read
    logic             strobe;     // Falling edge latches
    logic             bus_oe;     // High while driving the bus
    logic [BUS_W-1:0] bus_out;    // Value driven on the bus
  } lcdc_disp_type;

  // Init command table
  function automatic logic [7:0] init_cmd(input logic [2:0] idx);
    case (idx)
      3'h0:    init_cmd = CMD_FUNC;
      3'h1:    init_cmd = CMD_FUNC;
      3'h2:    init_cmd = CMD_ON;
      3'h3:    init_cmd = CMD_CLEAR;
      3'h4:    init_cmd = CMD_ENTRY;
      default: init_cmd = CMD_ROW0;
    endcase
  endfunction : init_cmd

endpackage : lcdc_pkg

/* src/lcdc_top.sv */
//******************************************************************************
// Purpose: Character display controller: init, power-on message, host writes
// Assumes: Flash port runs on clk; display and host pins are asynchronous
// Notes:   All display timing is paced by a ~43 kHz step enable
//******************************************************************************
`timescale 1ns/100ps
// How it works
// - Wait fixed 15 ms after each init command
// - Poll busy flag after every data write
// - Read select low writes, high reads
// - Register select low command, high data
// - Strobe falling edge latches writes; read data is sampled while strobe is high
// - Bidirectional 8-bit bus, released during reads
// - Reset reruns the whole init sequence
// - Acknowledge high once character is delivered
// - Data ignored until acknowledge goes low
// - Nine-bit flash address output
// - Active-low read strobe with address held
// - Flash message shown right after startup
// - Sequencer has exactly eight states
// - Init, then message, then host writes
// - Divider slows timing to suit display
// - Oscillator enable at about 5.5 MHz
// - Sequencer step at about 43 kHz
// - Flash data is upper byte of word
// - Sample flash data only while valid
module lcdc_top #(
  parameter logic [5:0] OSC_DIV_P    = lcdc_pkg::OSC_DIV,   // Clocks per oscillator tick
  parameter logic [7:0] STEP_DIV_P   = lcdc_pkg::STEP_DIV,  // Oscillator ticks per step
  parameter logic [9:0] WAIT_STEPS_P = lcdc_pkg::WAIT_STEPS // Steps of init wait
) (
  input  wire logic                        clk,                // 250 MHz clock
  input  wire logic                        rst,                // Sync reset, high
  input  wire logic [lcdc_pkg::BUS_W-1:0]  display_bus_in,     // Bus level seen at pins
  output logic      [lcdc_pkg::BUS_W-1:0]  display_bus_out,    // Bus value driven
  output logic                             display_bus_oe,     // High while driving bus
  output logic                             display_reg_select, // Register select
  output logic                             display_rw,         // Read/write select
  output logic                             display_strobe,     // Enable strobe
  input  wire logic [lcdc_pkg::BUS_W-1:0]  host_char_in,       // Host ASCII code
  input  wire logic                        host_we_n,          // Write request, low
  output logic                             host_ack,           // Character delivered
  output logic      [lcdc_pkg::ADDR_W-1:0] flash_addr,         // Message flash address
  output logic                             flash_read_n,       // Flash read, low
  input  wire logic [lcdc_pkg::BUS_W-1:0]  flash_data,         // Upper byte of word
  input  wire logic                        flash_valid         // Flash data valid
);
  //****************************************************************************
  // Input synchronisers
  //****************************************************************************
  logic [lcdc_pkg::IN_W-1:0] sync1_r, sync2_r, sync3_r, filt_r; // Three stages and filtered
  logic [lcdc_pkg::IN_W-1:0] sync1_nxt, sync2_nxt, sync3_nxt, filt_nxt;
  // Each bit moves only when its own stages two and three agree,
  // so a bus that keeps changing cannot stall the write request
  always_comb begin
    sync1_nxt = {host_we_n, host_char_in, display_bus_in};
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
    filt_nxt  = ((sync2_r ~^ sync3_r) & sync3_r) | ((sync2_r ^ sync3_r) & filt_r);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= lcdc_pkg::IN_RST;
      sync2_r <= lcdc_pkg::IN_RST;
      sync3_r <= lcdc_pkg::IN_RST;
      filt_r  <= lcdc_pkg::IN_RST;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sync3_r <= sync3_nxt;
      filt_r  <= filt_nxt;
    end
  end
  logic                       we_n_f;  // Filtered write request
  logic [lcdc_pkg::BUS_W-1:0] char_f;  // Filtered host character
  logic [lcdc_pkg::BUS_W-1:0] bus_f;   // Filtered display bus
  assign {we_n_f, char_f, bus_f} = filt_r;
  //****************************************************************************
  // Clock divider
  //****************************************************************************
  logic [5:0] osc_cnt_r, osc_cnt_nxt;     // Oscillator divider
  logic [7:0] step_cnt_r, step_cnt_nxt;   // Step divider
  logic       step_tick_r, step_tick_nxt; // One-cycle step enable
  logic       osc_tick;                   // Oscillator enable
  // Enables instead of derived clocks keep everything in one domain
  always_comb begin
    osc_tick      = (osc_cnt_r == OSC_DIV_P - 6'h01);
    osc_cnt_nxt   = osc_tick ? 6'h00 : osc_cnt_r + 6'h01;
    step_cnt_nxt  = step_cnt_r;
    step_tick_nxt = 1'b0;
    if (osc_tick) begin
      if (step_cnt_r == STEP_DIV_P - 8'h01) begin
        step_cnt_nxt  = 8'h00;
        step_tick_nxt = 1'b1;
      end else begin
        step_cnt_nxt = step_cnt_r + 8'h01;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      osc_cnt_r   <= 6'h00;
      step_cnt_r  <= 8'h00;
      step_tick_r <= 1'b0;
    end else begin
      osc_cnt_r   <= osc_cnt_nxt;
      step_cnt_r  <= step_cnt_nxt;
      step_tick_r <= step_tick_nxt;
    end
  end
  //****************************************************************************
  // Sequencer
  //****************************************************************************
  lcdc_pkg::lcdc_state_type state_r, state_nxt;
  logic [1:0]                 phase_r, phase_nxt;     // Bus cycle phase
  logic [9:0]                 wait_r, wait_nxt;       // Init wait counter
  logic [2:0]                 init_idx_r, init_idx_nxt; // Init command index
  logic [4:0]                 msg_idx_r, msg_idx_nxt; // Message character index
  logic [4:0]                 pos_r, pos_nxt;         // Cursor position
  logic                       msg_mode_r, msg_mode_nxt; // Showing power-on message
  logic [7:0]                 wr_byte_r, wr_byte_nxt; // Byte to write
  logic                       wr_rs_r, wr_rs_nxt;     // Byte is data
  logic                       busy_r, busy_nxt;       // Sampled busy flag
  logic                       ack_r, ack_nxt;         // Acknowledge
  logic                       rd_n_r, rd_n_nxt;       // Flash read strobe
  logic [lcdc_pkg::ADDR_W-1:0] addr_r, addr_nxt;      // Flash address
  lcdc_pkg::lcdc_disp_type    disp_r, disp_nxt;       // Display pins
  logic                       cyc_end;                // Last phase of a bus cycle
  always_comb begin
    state_nxt    = state_r;
    phase_nxt    = phase_r;
    wait_nxt     = wait_r;
    init_idx_nxt = init_idx_r;
    msg_idx_nxt  = msg_idx_r;
    pos_nxt      = pos_r;
    msg_mode_nxt = msg_mode_r;
    wr_byte_nxt  = wr_byte_r;
    wr_rs_nxt    = wr_rs_r;
    busy_nxt     = busy_r;
    cyc_end      = step_tick_r && (phase_r == lcdc_pkg::PH_HOLD);
    // Phase walks one step per tick inside bus cycles
    if (step_tick_r && (state_r inside {lcdc_pkg::ST_INIT_CMD, lcdc_pkg::ST_WRITE, lcdc_pkg::ST_BUSY_RD})) begin
      phase_nxt = phase_r + 2'h1;
    end
    case (state_r)
      lcdc_pkg::ST_POWER: begin
        // Power-up settle before the first command
        if (step_tick_r) wait_nxt = wait_r + 10'h001;
        if (wait_r == WAIT_STEPS_P) begin
          wait_nxt    = 10'h000;
          wr_byte_nxt = lcdc_pkg::init_cmd(3'h0);
          wr_rs_nxt   = 1'b0;
          state_nxt   = lcdc_pkg::ST_INIT_CMD;
        end
      end
      lcdc_pkg::ST_INIT_CMD: if (cyc_end) state_nxt = lcdc_pkg::ST_INIT_WAIT;
      lcdc_pkg::ST_INIT_WAIT: begin
        // Fixed wait instead of busy polling keeps init simple
        if (step_tick_r) wait_nxt = wait_r + 10'h001;
        if (wait_r == WAIT_STEPS_P) begin
          wait_nxt = 10'h000;
          if (init_idx_r == lcdc_pkg::INIT_LAST) begin
            state_nxt = lcdc_pkg::ST_MSG_READ;
          end else begin
            init_idx_nxt = init_idx_r + 3'h1;
            wr_byte_nxt  = lcdc_pkg::init_cmd(init_idx_r + 3'h1);
            state_nxt    = lcdc_pkg::ST_INIT_CMD;
          end
        end
      end
      lcdc_pkg::ST_MSG_READ: begin
        // Byte taken only with valid high and the read strobe low
        if (!rd_n_r && flash_valid) begin
          wr_byte_nxt = flash_data;
          wr_rs_nxt   = 1'b1;
          state_nxt   = lcdc_pkg::ST_WRITE;
        end
      end
      lcdc_pkg::ST_WRITE: if (cyc_end) state_nxt = lcdc_pkg::ST_BUSY_RD;
      lcdc_pkg::ST_BUSY_RD: begin
        // Sample while the strobe is still high, just before it falls
        if (step_tick_r && (phase_r == lcdc_pkg::PH_HIGH)) busy_nxt = bus_f[lcdc_pkg::BUSY_BIT];
        if (cyc_end) begin
          if (busy_r) begin
            state_nxt = lcdc_pkg::ST_BUSY_RD;
          end else if (wr_rs_r && ((pos_r + 5'h01) == lcdc_pkg::ROW1_POS)) begin
            // Rows are not contiguous, so jump the cursor explicitly
            pos_nxt     = pos_r + 5'h01;
            wr_byte_nxt = lcdc_pkg::CMD_ROW1;
            wr_rs_nxt   = 1'b0;
            state_nxt   = lcdc_pkg::ST_WRITE;
          end else if (wr_rs_r && ((pos_r + 5'h01) == 5'h00)) begin
            pos_nxt     = 5'h00;
            wr_byte_nxt = lcdc_pkg::CMD_ROW0;
            wr_rs_nxt   = 1'b0;
            state_nxt   = lcdc_pkg::ST_WRITE;
          end else begin
            if (wr_rs_r) pos_nxt = pos_r + 5'h01;
            if (msg_mode_r && (msg_idx_r != lcdc_pkg::MSG_LAST)) begin
              msg_idx_nxt = msg_idx_r + 5'h01;
              state_nxt   = lcdc_pkg::ST_MSG_READ;
            end else if (msg_mode_r) begin
              msg_mode_nxt = 1'b0;
              state_nxt    = lcdc_pkg::ST_IDLE;
            end else begin
              state_nxt = lcdc_pkg::ST_ACK;
            end
          end
        end
      end
      lcdc_pkg::ST_IDLE: begin
        if (!we_n_f) begin
          wr_byte_nxt = char_f;
          wr_rs_nxt   = 1'b1;
          state_nxt   = lcdc_pkg::ST_WRITE;
        end
      end
      // Host data is ignored until the request is released
      lcdc_pkg::ST_ACK: if (we_n_f) state_nxt = lcdc_pkg::ST_IDLE;
      default: state_nxt = lcdc_pkg::ST_POWER;
    endcase
    if (state_nxt != state_r) phase_nxt = lcdc_pkg::PH_SETUP;
    // Registered outputs follow the next state
    ack_nxt  = (state_nxt == lcdc_pkg::ST_ACK);
    rd_n_nxt = (state_nxt != lcdc_pkg::ST_MSG_READ);
    addr_nxt = lcdc_pkg::ADDR_W'(msg_idx_nxt);
    disp_nxt = '0;
    if (state_nxt inside {lcdc_pkg::ST_INIT_CMD, lcdc_pkg::ST_WRITE}) begin
      // Controls set in setup phase and held through hold phase
      disp_nxt.reg_select = wr_rs_nxt;
      disp_nxt.read_sel   = 1'b0;
      disp_nxt.bus_oe     = 1'b1;
      disp_nxt.bus_out    = wr_byte_nxt;
      disp_nxt.strobe     = (phase_nxt == lcdc_pkg::PH_HIGH);
    end else if (state_nxt == lcdc_pkg::ST_BUSY_RD) begin
      disp_nxt.read_sel = 1'b1;
      disp_nxt.strobe   = (phase_nxt == lcdc_pkg::PH_HIGH);
    end
  end
  // Reset returns to power-up and reruns the init sequence
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r    <= lcdc_pkg::ST_POWER;
      phase_r    <= lcdc_pkg::PH_SETUP;
      wait_r     <= 10'h000;
      init_idx_r <= 3'h0;
      msg_idx_r  <= 5'h00;
      pos_r      <= 5'h00;
      msg_mode_r <= 1'b1;
      wr_byte_r  <= 8'h00;
      wr_rs_r    <= 1'b0;
      busy_r     <= 1'b0;
      ack_r      <= 1'b0;
      rd_n_r     <= 1'b1;
      addr_r     <= 9'h000;
      disp_r     <= '0;
    end else begin
      state_r    <= state_nxt;
      phase_r    <= phase_nxt;
      wait_r     <= wait_nxt;
      init_idx_r <= init_idx_nxt;
      msg_idx_r  <= msg_idx_nxt;
      pos_r      <= pos_nxt;
      msg_mode_r <= msg_mode_nxt;
      wr_byte_r  <= wr_byte_nxt;
      wr_rs_r    <= wr_rs_nxt;
      busy_r     <= busy_nxt;
      ack_r      <= ack_nxt;
      rd_n_r     <= rd_n_nxt;
      addr_r     <= addr_nxt;
      disp_r     <= disp_nxt;
    end
  end
  assign {display_reg_select, display_rw, display_strobe, display_bus_oe, display_bus_out} = disp_r;
  assign host_ack           = ack_r;
  assign flash_addr         = addr_r;
  assign flash_read_n       = rd_n_r;
  //****************************************************************************
  // Assertions
  //****************************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  strobe_ctrl_stable_a : assert property ((disp_r.strobe || $fell(disp_r.strobe)) |-> $stable(disp_r.reg_select) && $stable(disp_r.read_sel) && $stable(disp_r.bus_out)) else $error("Controls moved around strobe");
  read_bus_free_a : assert property (disp_r.read_sel |-> !disp_r.bus_oe) else $error("Bus driven during read");
  write_bus_drive_a : assert property ((disp_r.strobe && !disp_r.read_sel) |-> disp_r.bus_oe) else $error("Write strobe without bus drive");
  init_cmd_reg_a : assert property ((state_r == lcdc_pkg::ST_INIT_CMD) |-> !disp_r.reg_select && !disp_r.read_sel) else $error("Init not a command write");
  init_wait_hold_a : assert property ((state_r == lcdc_pkg::ST_INIT_WAIT && wait_r != WAIT_STEPS_P) |=> state_r == lcdc_pkg::ST_INIT_WAIT) else $error("Init wait cut short");
  write_then_busy_a : assert property ((state_r == lcdc_pkg::ST_WRITE && state_nxt != lcdc_pkg::ST_WRITE) |=> state_r == lcdc_pkg::ST_BUSY_RD) else $error("No busy poll after write");
  busy_repeat_a : assert property ((state_r == lcdc_pkg::ST_BUSY_RD && cyc_end && busy_r) |=> state_r == lcdc_pkg::ST_BUSY_RD && phase_r == lcdc_pkg::PH_SETUP) else $error("Left busy poll while busy");
  flash_read_low_a : assert property ((state_r == lcdc_pkg::ST_MSG_READ && $past(state_r) == lcdc_pkg::ST_MSG_READ) |-> !flash_read_n && flash_addr == lcdc_pkg::ADDR_W'(msg_idx_r)) else $error("Flash read strobe wrong");
  ack_after_poll_a : assert property ($rose(host_ack) |-> $past(state_r) == lcdc_pkg::ST_BUSY_RD && !$past(busy_r)) else $error("Ack without delivery");
  ack_ignore_data_a : assert property ((state_r == lcdc_pkg::ST_ACK && !we_n_f) |=> state_r == lcdc_pkg::ST_ACK && host_ack) else $error("Data taken while ack high");
  step_tick_gap_a : assert property (step_tick_r |=> !step_tick_r [*2]) else $error("Step enable too frequent");
  reset_restart_a : assert property ($past(rst) |-> state_r == lcdc_pkg::ST_POWER && init_idx_r == 3'h0) else $error("Reset did not restart");
endmodule : lcdc_top
